// ---- rtl/pmic_i2c_pkg.sv ----
// Constants, state encodings and state records for the two-wire register slave.
// Assumes a single user of the records: the slave module in pmic_i2c_slave.sv.
package pmic_i2c_pkg;

  // Bus speed ceilings of the four speed ranges, in Hz
  localparam int STD_MAX_HZ = 100000;
  localparam int FAST_MAX_HZ = 400000;
  localparam int FPLUS_MAX_HZ = 1000000;
  localparam int HS_MAX_HZ = 3400000;

  // Default sampling clock of the bus-facing logic, in Hz
  localparam int LINK_HZ_DEFAULT = 20833333;

  // Slave addresses picked by the two-bit address option, index 0 in the low slice
  localparam logic [3:0][6:0] MAIN_ADDR_TABLE = {7'h52, 7'h48, 7'h44, 7'h40};
  localparam logic [6:0] TEST_ADDR = 7'h49;

  // Bits per byte on the wire before the acknowledge slot
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] TX_LAST_FALL = 4'h7;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_ACK,
    ST_TX,
    ST_TXACK,
    ST_IGNORE
  } link_state_e;

  typedef enum logic [1:0] {
    PH_ADDR,
    PH_PTR,
    PH_DATA
  } phase_e;

  typedef struct packed {
    logic rst_m, rst_s;
    logic scl_m, scl_s, sda_m, sda_s;
    logic [1:0] sel_m, sel_s;
    logic tst_m, tst_s;
    logic ack_m, ack_s, ack_p;
    logic scl_f, sda_f, scl_p, sda_p;
    logic [3:0] scl_cnt, sda_cnt;
    logic otp_done;
    logic [6:0] own_addr;
    link_state_e state;
    phase_e phase;
    logic [7:0] shreg;
    logic [3:0] bitcnt;
    logic rw, nack, sda_low;
    logic [7:0] ptr, rd_addr, wr_addr, wr_data, rdbuf;
    logic commit_pend, wr_tog, rd_tog;
  } link_s;

  typedef struct packed {
    logic wt_m, wt_s, wt_p;
    logic rt_m, rt_s, rt_p;
    logic wr_valid;
    logic [7:0] wr_addr, wr_data;
    logic rd_req, rd_pend;
    logic [7:0] rd_addr, rd_data;
    logic rd_ack_tog;
  } core_s;

  localparam link_s LINK_RST = link_s'('0);
  localparam core_s CORE_RST = core_s'('0);

endpackage

// ---- rtl/pmic_i2c_slave.sv ----
// Two-wire serial register slave: bus engine on link_clk, register port on core_clk.
// Assumes open-drain SDA/SCL with external pull-ups and a register file that
// answers rd_addr with rd_data one core_clk cycle after rd_req.
//
// Operation
// - Slave only; the master makes every clock pulse, SCL is never driven.
// - Works for any SCL rate down to a paused clock; no timeouts.
// - Handles standard, fast, fast-plus and high-speed rate ranges.
// - One data bit per SCL cycle, sampled while SCL is high.
// - SDA only changes while SCL is low.
// - SDA fall with SCL high is START, SDA rise with SCL high is STOP.
// - Both lines released when no transfer is in progress.
// - Each byte is eight data bits plus one acknowledge bit.
// - Bytes travel most significant bit first.
// - Repeated START restarts address reception like a fresh START.
// - The receiving party generates the acknowledge for each byte.
// - Acknowledge pulls SDA low before ninth rise and through its high phase.
// - Not-acknowledge leaves SDA high across the ninth clock.
// - Every register pointer value is acknowledged, mapped or not.
// - Only 7-bit slave addresses, taken right after a START.
// - Own address comes from a one-time address option strap.
// - Only the main address and unlocked test address are acknowledged.
// - Option 0..3 selects 0x40/0x44/0x48/0x52; 0x49 only in test mode.
// - SCL is never held low; no clock stretching.
// - General call address is refused and its transaction ignored.
// - After an acknowledged write byte, next SDA rise commits it, or the next byte's eighth SCL fall if no rise comes first.
`timescale 1ns/1ps

module pmic_i2c_slave #(
  parameter int LINK_HZ = pmic_i2c_pkg::LINK_HZ_DEFAULT
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic link_clk,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  input wire logic [1:0] addr_sel,
  input wire logic test_unlock,
  output logic wr_valid,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data,
  output logic rd_req,
  output logic [7:0] rd_addr,
  input wire logic [7:0] rd_data
);

  // The glitch filter must settle well inside a quarter of a high-speed period,
  // so one filter length serves every speed range up to the fastest
  // Trade-off: one setting rejects less noise in the slower ranges than a
  // per-range filter would, but needs no tracking of the current speed range
  localparam int FILT_RAW = LINK_HZ / (pmic_i2c_pkg::HS_MAX_HZ * 4);
  localparam int FILT_CYC = (FILT_RAW < 1) ? 1 : ((FILT_RAW > 15) ? 15 : FILT_RAW);
  localparam logic [3:0] FILT_LAST = 4'(FILT_CYC - 1);

  pmic_i2c_pkg::link_s l_q;
  pmic_i2c_pkg::link_s l_d;
  pmic_i2c_pkg::core_s c_q;
  pmic_i2c_pkg::core_s c_d;

  logic scl_rise;
  logic scl_fall;
  logic sda_rise;
  logic start_seen;
  logic stop_seen;
  logic addr_hit;
  logic main_hit;
  logic test_hit;

  // Events use filtered levels only, never the raw synchroniser stages
  assign scl_rise = l_q.scl_f & ~l_q.scl_p;
  assign scl_fall = ~l_q.scl_f & l_q.scl_p;
  assign sda_rise = l_q.sda_f & ~l_q.sda_p;
  assign start_seen = l_q.scl_f & l_q.scl_p & l_q.sda_p & ~l_q.sda_f;
  assign stop_seen = l_q.scl_f & l_q.scl_p & ~l_q.sda_p & l_q.sda_f;

  // All-zero general call never matches either entry, so it is refused
  // The test address is only honoured while the unlock level stands
  assign main_hit = (l_q.shreg[7:1] == l_q.own_addr);
  assign test_hit = l_q.tst_s && (l_q.shreg[7:1] == pmic_i2c_pkg::TEST_ADDR);
  assign addr_hit = main_hit || test_hit;

  // Link domain: sampled by link_clk, which runs free; SCL is data here,
  // so a stopped or arbitrarily slow SCL simply produces no events.
  // No timeout counter exists: a transfer paused for any length of time
  // resumes exactly where it stopped.
  always_comb begin
    l_d = l_q;
    l_d.rst_m = reset;
    l_d.rst_s = l_q.rst_m;
    l_d.scl_m = scl_i;
    l_d.scl_s = l_q.scl_m;
    l_d.sda_m = sda_i;
    l_d.sda_s = l_q.sda_m;
    l_d.sel_m = addr_sel;
    l_d.sel_s = l_q.sel_m;
    l_d.tst_m = test_unlock;
    l_d.tst_s = l_q.tst_m;
    l_d.ack_m = c_q.rd_ack_tog;
    l_d.ack_s = l_q.ack_m;
    l_d.ack_p = l_q.ack_s;
    l_d.scl_p = l_q.scl_f;
    l_d.sda_p = l_q.sda_f;

    // A new level must persist FILT_CYC samples before it is believed
    if (l_q.scl_s != l_q.scl_f) begin
      l_d.scl_cnt = l_q.scl_cnt + 4'h1;
      if (l_q.scl_cnt >= FILT_LAST) begin
        l_d.scl_f = l_q.scl_s;
        l_d.scl_cnt = 4'h0;
      end
    end else begin
      l_d.scl_cnt = 4'h0;
    end
    if (l_q.sda_s != l_q.sda_f) begin
      l_d.sda_cnt = l_q.sda_cnt + 4'h1;
      if (l_q.sda_cnt >= FILT_LAST) begin
        l_d.sda_f = l_q.sda_s;
        l_d.sda_cnt = 4'h0;
      end
    end else begin
      l_d.sda_cnt = 4'h0;
    end

    // Strap is caught once, after the release of reset
    if (!l_q.otp_done) begin
      l_d.own_addr = pmic_i2c_pkg::MAIN_ADDR_TABLE[l_q.sel_s];
      l_d.otp_done = 1'b1;
    end

    // Read data word crossing: the core holds rd_data until its next toggle
    // Only the toggle is synchronised; the word is steady when it is taken
    if (l_q.ack_s != l_q.ack_p) begin
      l_d.rdbuf = c_q.rd_data;
    end

    // The rising SDA edge after an acknowledged write byte commits it
    if (sda_rise && l_q.commit_pend) begin
      l_d.wr_tog = ~l_q.wr_tog;
      l_d.commit_pend = 1'b0;
    end

    if (start_seen) begin
      l_d.state = pmic_i2c_pkg::ST_RX;
      l_d.phase = pmic_i2c_pkg::PH_ADDR;
      l_d.bitcnt = 4'h0;
      l_d.sda_low = 1'b0;
    end else if (stop_seen) begin
      l_d.state = pmic_i2c_pkg::ST_IDLE;
      l_d.sda_low = 1'b0;
    end else begin
      case (l_q.state)
        pmic_i2c_pkg::ST_RX: begin
          if (scl_rise) begin
            l_d.shreg = {l_q.shreg[6:0], l_q.sda_f};
            l_d.bitcnt = l_q.bitcnt + 4'h1;
          end else if (scl_fall && (l_q.bitcnt == pmic_i2c_pkg::BYTE_BITS)) begin
            l_d.bitcnt = 4'h0;
            case (l_q.phase)
              pmic_i2c_pkg::PH_ADDR: begin
                if (addr_hit) begin
                  l_d.rw = l_q.shreg[0];
                  l_d.state = pmic_i2c_pkg::ST_ACK;
                  l_d.sda_low = 1'b1;
                end else begin
                  l_d.state = pmic_i2c_pkg::ST_IGNORE;
                end
              end
              pmic_i2c_pkg::PH_PTR: begin
                l_d.ptr = l_q.shreg;
                l_d.rd_addr = l_q.shreg;
                l_d.rd_tog = ~l_q.rd_tog;
                l_d.state = pmic_i2c_pkg::ST_ACK;
                l_d.sda_low = 1'b1;
              end
              default: begin
                // A write still waiting for its SDA rise is committed now,
                // before its holding word is replaced at this byte's ack end
                if (l_q.commit_pend) begin
                  l_d.wr_tog = ~l_q.wr_tog;
                  l_d.commit_pend = 1'b0;
                end
                l_d.state = pmic_i2c_pkg::ST_ACK;
                l_d.sda_low = 1'b1;
              end
            endcase
          end
        end
        pmic_i2c_pkg::ST_ACK: begin
          // Release on the fall that ends the ninth pulse
          if (scl_fall) begin
            l_d.sda_low = 1'b0;
            case (l_q.phase)
              pmic_i2c_pkg::PH_ADDR: begin
                if (l_q.rw) begin
                  l_d.state = pmic_i2c_pkg::ST_TX;
                  l_d.shreg = l_q.rdbuf;
                  l_d.sda_low = ~l_q.rdbuf[7];
                  l_d.ptr = l_q.ptr + 8'h01;
                  l_d.rd_addr = l_q.ptr + 8'h01;
                  l_d.rd_tog = ~l_q.rd_tog;
                end else begin
                  l_d.state = pmic_i2c_pkg::ST_RX;
                  l_d.phase = pmic_i2c_pkg::PH_PTR;
                end
              end
              pmic_i2c_pkg::PH_PTR: begin
                l_d.state = pmic_i2c_pkg::ST_RX;
                l_d.phase = pmic_i2c_pkg::PH_DATA;
              end
              default: begin
                l_d.state = pmic_i2c_pkg::ST_RX;
                l_d.wr_addr = l_q.ptr;
                l_d.wr_data = l_q.shreg;
                l_d.commit_pend = 1'b1;
                l_d.ptr = l_q.ptr + 8'h01;
                l_d.rd_addr = l_q.ptr + 8'h01;
                l_d.rd_tog = ~l_q.rd_tog;
              end
            endcase
          end
        end
        pmic_i2c_pkg::ST_TX: begin
          // Data moves only on SCL falls, so it is steady while SCL is high
          if (scl_fall) begin
            if (l_q.bitcnt == pmic_i2c_pkg::TX_LAST_FALL) begin
              l_d.sda_low = 1'b0;
              l_d.bitcnt = 4'h0;
              l_d.state = pmic_i2c_pkg::ST_TXACK;
            end else begin
              l_d.sda_low = ~l_q.shreg[6];
              l_d.shreg = {l_q.shreg[6:0], 1'b0};
              l_d.bitcnt = l_q.bitcnt + 4'h1;
            end
          end
        end
        pmic_i2c_pkg::ST_TXACK: begin
          if (scl_rise) begin
            l_d.nack = l_q.sda_f;
          end else if (scl_fall) begin
            if (l_q.nack) begin
              l_d.state = pmic_i2c_pkg::ST_IGNORE;
            end else begin
              l_d.state = pmic_i2c_pkg::ST_TX;
              l_d.shreg = l_q.rdbuf;
              l_d.sda_low = ~l_q.rdbuf[7];
              l_d.ptr = l_q.ptr + 8'h01;
              l_d.rd_addr = l_q.ptr + 8'h01;
              l_d.rd_tog = ~l_q.rd_tog;
            end
          end
        end
        pmic_i2c_pkg::ST_IGNORE: begin
          // Stays here until START or STOP; data bits of a refused frame
          // never reach the shift register's consumers
          l_d.sda_low = 1'b0;
        end
        default: begin
          l_d.state = pmic_i2c_pkg::ST_IDLE;
          l_d.sda_low = 1'b0;
        end
      endcase
    end

    // Reset keeps the pin synchroniser pipelines moving and clears the rest, read-ack synchroniser included
    // Filtered levels restart at the idle high level, so no false START or
    // STOP is seen on the first cycles after reset
    if (l_q.rst_s) begin
      l_d = pmic_i2c_pkg::LINK_RST;
      l_d.rst_m = reset;
      l_d.rst_s = l_q.rst_m;
      l_d.scl_m = scl_i;
      l_d.scl_s = l_q.scl_m;
      l_d.sda_m = sda_i;
      l_d.sda_s = l_q.sda_m;
      l_d.sel_m = addr_sel;
      l_d.sel_s = l_q.sel_m;
      l_d.tst_m = test_unlock;
      l_d.tst_s = l_q.tst_m;
      l_d.scl_f = 1'b1;
      l_d.sda_f = 1'b1;
      l_d.scl_p = 1'b1;
      l_d.sda_p = 1'b1;
    end
  end

  // Reset reaches this domain through rst_m/rst_s, hence no reset branch here
  always_ff @(posedge link_clk) begin
    l_q <= l_d;
  end

  // Core domain: turns the link's toggles into register port pulses
  // Each toggle passes two flip-flops; the address and data words it guards
  // were written by the link several cycles earlier and stay put until the
  // next toggle, so they are read here without their own synchroniser.
  // Hazard: a new toggle sooner than four core cycles would be merged.
  always_comb begin
    c_d = c_q;
    c_d.wt_m = l_q.wr_tog;
    c_d.wt_s = c_q.wt_m;
    c_d.wt_p = c_q.wt_s;
    c_d.rt_m = l_q.rd_tog;
    c_d.rt_s = c_q.rt_m;
    c_d.rt_p = c_q.rt_s;
    c_d.wr_valid = c_q.wt_s ^ c_q.wt_p;
    if (c_q.wt_s ^ c_q.wt_p) begin
      c_d.wr_addr = l_q.wr_addr;
      c_d.wr_data = l_q.wr_data;
    end
    c_d.rd_req = c_q.rt_s ^ c_q.rt_p;
    if (c_q.rt_s ^ c_q.rt_p) begin
      c_d.rd_addr = l_q.rd_addr;
    end
    // Prefetch: the next read byte is fetched long before the master needs
    // it, which is what lets the slave avoid holding SCL low
    c_d.rd_pend = c_q.rd_req;
    if (c_q.rd_pend) begin
      c_d.rd_data = rd_data;
      c_d.rd_ack_tog = ~c_q.rd_ack_tog;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      c_q <= pmic_i2c_pkg::CORE_RST;
    end else begin
      c_q <= c_d;
    end
  end

  // Open drain: only ever pulls low; SCL has no output at all
  assign sda_o = 1'b0;
  assign sda_oe_n = ~l_q.sda_low;
  assign wr_valid = c_q.wr_valid;
  assign wr_addr = c_q.wr_addr;
  assign wr_data = c_q.wr_data;
  assign rd_req = c_q.rd_req;
  assign rd_addr = c_q.rd_addr;

endmodule

// ---- tb/pmic_i2c_chk.sv ----
// Port-level checker for the two-wire register slave.
// Assumes it is bound to pmic_i2c_slave; reset is held while lines may be unknown.
`timescale 1ns/1ps
module pmic_i2c_chk (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic link_clk,
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe_n,
  input wire logic wr_valid,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic rd_req,
  input wire logic [7:0] rd_addr
);
  logic [3:0] lo_cnt_q;

  // Link cycles spent in the current SCL low phase, saturating
  always_ff @(posedge link_clk) begin
    if (scl_i) lo_cnt_q <= 4'h0;
    else if (lo_cnt_q != 4'hF) lo_cnt_q <= lo_cnt_q + 4'h1;
  end

  a_open_drain: assert property (@(posedge core_clk) disable iff (reset)
    sda_o == 1'b0) else $error("sda_o driven high");
  // No disable here: this one is about the reset itself
  a_reset_quiet: assert property (@(posedge core_clk) reset [*8]
    |=> sda_oe_n && !wr_valid && !rd_req) else $error("outputs busy in reset");
  a_wr_pulse: assert property (@(posedge core_clk) disable iff (reset)
    wr_valid |=> !wr_valid [*8]) else $error("write strobe too long");
  a_rd_pulse: assert property (@(posedge core_clk) disable iff (reset)
    rd_req |=> !rd_req [*8]) else $error("read request too long");
  a_wr_hold: assert property (@(posedge core_clk) disable iff (reset)
    !wr_valid |-> $stable(wr_addr) && $stable(wr_data)) else $error("write data moved");
  a_rd_hold: assert property (@(posedge core_clk) disable iff (reset)
    !rd_req |-> $stable(rd_addr)) else $error("read address moved");
  // Drive changes only early in the SCL low phase
  a_oe_timing: assert property (@(posedge link_clk) disable iff (reset)
    $changed(sda_oe_n) |-> lo_cnt_q inside {[4'h1:4'h7]}) else $error("sda drive mistimed");
  a_ack_held: assert property (@(posedge link_clk) disable iff (reset)
    $fell(sda_oe_n) |=> !sda_oe_n [*8]) else $error("sda pull not held");

  c_write: cover property (@(posedge core_clk) disable iff (reset) wr_valid);
  c_read: cover property (@(posedge core_clk) disable iff (reset) rd_req);
  c_pull: cover property (@(posedge link_clk) disable iff (reset) $fell(sda_oe_n));
endmodule

bind pmic_i2c_slave pmic_i2c_chk chk (
  .core_clk(core_clk), .reset(reset), .link_clk(link_clk), .scl_i(scl_i),
  .sda_o(sda_o), .sda_oe_n(sda_oe_n), .wr_valid(wr_valid), .wr_addr(wr_addr),
  .wr_data(wr_data), .rd_req(rd_req), .rd_addr(rd_addr)
);

// ---- tb/pmic_i2c_master.sv ----
// Behavioural bus master: makes every SCL pulse and drives SDA open drain.
// Assumes the bench forms the wired-AND of SDA and feeds it back on sda_in.
`timescale 1ns/1ps
module pmic_i2c_master #(
  parameter int QTR_NS = 400
) (
  output logic scl_o,
  output logic sda_o,
  input wire logic sda_in
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // Also serves as repeated START: lines are raised in the low phase first
  task automatic start();
    sda_o = 1'b1;
    #(QTR_NS);
    scl_o = 1'b1;
    #(QTR_NS);
    sda_o = 1'b0;
    #(QTR_NS);
    scl_o = 1'b0;
    #(QTR_NS);
  endtask

  // Eight data bits then the acknowledge slot; a 1 releases SDA to the pull-up
  task automatic bits9(input logic [8:0] tx, output logic [8:0] rx);
    for (int k = 8; k >= 0; k--) begin
      sda_o = tx[k];
      #(QTR_NS);
      scl_o = 1'b1;
      #(QTR_NS);
      rx[k] = sda_in;
      #(QTR_NS);
      scl_o = 1'b0;
      #(QTR_NS);
    end
  endtask

  task automatic stop();
    sda_o = 1'b0;
    #(QTR_NS);
    scl_o = 1'b1;
    #(QTR_NS);
    sda_o = 1'b1;
    #(QTR_NS);
  endtask
endmodule

// ---- tb/tb_pmic_i2c_slave_interface.sv ----
// Self-checking bench for the two-wire register slave.
// Assumes a register file answering rd_addr XOR 8'h5A, registered on the falling core_clk edge.
`timescale 1ns/1ps
module tb_pmic_i2c_slave_interface;
  logic core_clk = 1'b0;
  logic link_clk = 1'b0;
  logic reset = 1'b1;
  logic [1:0] addr_sel = 2'h0;
  logic test_unlock = 1'b0;
  logic [7:0] rd_data = 8'h00;
  logic scl_m, sda_m, sda_o, sda_oe_n, wr_valid, rd_req;
  logic [7:0] wr_addr, wr_data, rd_addr;
  logic [15:0] wr_log[$];
  wire sda_w = sda_m & (sda_oe_n | sda_o);
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;

  initial forever #20 core_clk = ~core_clk;
  initial begin
    #7;
    forever #24 link_clk = ~link_clk;
  end

  pmic_i2c_slave uut (.core_clk(core_clk), .reset(reset), .link_clk(link_clk),
    .scl_i(scl_m), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .addr_sel(addr_sel), .test_unlock(test_unlock), .wr_valid(wr_valid),
    .wr_addr(wr_addr), .wr_data(wr_data), .rd_req(rd_req), .rd_addr(rd_addr),
    .rd_data(rd_data));
  pmic_i2c_master bus (.scl_o(scl_m), .sda_o(sda_m), .sda_in(sda_w));

  always @(negedge core_clk) rd_data <= rd_addr ^ 8'h5A;
  always @(posedge core_clk) if (wr_valid === 1'b1) wr_log.push_back({wr_addr, wr_data});

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  task automatic do_reset(input logic [1:0] sel);
    @(negedge core_clk);
    reset = 1'b1;
    addr_sel = sel;
    repeat (16) @(negedge core_clk);
    reset = 1'b0;
    repeat (10) @(negedge core_clk);
  endtask

  // Address byte with write bit; nack_exp is the wire level in the ack slot
  task automatic probe(input logic [6:0] a, input logic nack_exp);
    logic [8:0] r;
    bus.start();
    bus.bits9({a, 2'b01}, r);
    chk({15'h0, r[0]}, {15'h0, nack_exp}, "address acknowledge");
  endtask

  task automatic t_addresses();
    logic [6:0] main_a[4] = '{7'h40, 7'h44, 7'h48, 7'h52};
    logic [8:0] r;
    for (int s = 0; s < 4; s++) begin
      do_reset(s[1:0]);
      probe(main_a[s], 1'b0);
      bus.stop();
      probe(main_a[(s + 1) % 4], 1'b1);
      bus.stop();
      probe(7'h49, 1'b1);
      bus.stop();
    end
    @(negedge core_clk);
    test_unlock = 1'b1;
    // The refused test address is tried again once the unlock is given
    probe(7'h49, 1'b0);
    bus.stop();
    @(negedge core_clk);
    test_unlock = 1'b0;
    probe(7'h00, 1'b1);
    // The own address sent as data after a general call must go unanswered
    bus.bits9({7'h52, 2'b01}, r);
    chk({15'h0, r[0]}, 16'h0001, "general call follow-up");
    bus.stop();
  endtask

  task automatic t_write();
    logic [8:0] r;
    wr_log.delete();
    probe(7'h52, 1'b0);
    bus.bits9({8'hFF, 1'b1}, r);
    chk({15'h0, r[0]}, 16'h0000, "pointer acknowledge");
    bus.bits9({8'hA5, 1'b1}, r);
    chk({15'h0, r[0]}, 16'h0000, "data acknowledge");
    bus.bits9({8'h3C, 1'b1}, r);
    chk({15'h0, r[0]}, 16'h0000, "data acknowledge");
    bus.stop();
    repeat (20) @(negedge core_clk);
    chk(16'(wr_log.size()), 16'h0002, "write count");
    chk(wr_log[0], 16'hFFA5, "first write");
    chk(wr_log[1], 16'h003C, "wrapped write");
  endtask

  task automatic t_read();
    logic [8:0] r;
    probe(7'h52, 1'b0);
    bus.bits9({8'h10, 1'b1}, r);
    chk({15'h0, r[0]}, 16'h0000, "pointer acknowledge");
    bus.start();
    bus.bits9({7'h52, 2'b11}, r);
    chk({15'h0, r[0]}, 16'h0000, "read address after restart");
    bus.bits9({8'hFF, 1'b0}, r);
    chk({8'h0, r[8:1]}, 16'h004A, "first read byte");
    bus.bits9({8'hFF, 1'b1}, r);
    chk({8'h0, r[8:1]}, 16'h004B, "second read byte");
    bus.stop();
    repeat (10) @(negedge core_clk);
    chk({15'h0, sda_oe_n}, 16'h0001, "sda released when idle");
  endtask

  initial begin
    t_addresses();
    t_write();
    t_read();
    tally_and_finish();
  end
endmodule
